// ---- rtl/maf_pkg.sv ----
// Package of constants for the MAC address filter and user I/O block
// Behaviour
// - Four independent destination address match slots, each a low and a high register, are compared with received frames.
// - The low match register holds the low address bits, bit zero being the multicast bit of the first received byte.
// - The high match register holds address bits 47 to 32 in its low half; its upper half is reserved and reads zero.
// - A sixteen-bit software value is held and compared with the type/length field of each received frame.
// - A hardware-built pause frame carries the sixteen-bit transmit pause quantum register value as its quantum.
// - User I/O bit 0 set selects MII operation, cleared selects RMII operation.
// - With external match enable set, user I/O bit 1 set makes received frames be copied to memory; clear copies none.
// - A software toggle of user I/O bit 2 makes the device transmit one pause frame.
// - User I/O bit 3 selects zero or the transmit pause quantum register value as the transmitted quantum.
package maf_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Register byte offsets
  localparam logic [7:0] MAF_OFS_MATCH1_LOW  = 8'h00;
  localparam logic [7:0] MAF_OFS_MATCH1_HIGH = 8'h04;
  localparam logic [7:0] MAF_OFS_MATCH2_LOW  = 8'h08;
  localparam logic [7:0] MAF_OFS_MATCH2_HIGH = 8'h0C;
  localparam logic [7:0] MAF_OFS_MATCH3_LOW  = 8'h10;
  localparam logic [7:0] MAF_OFS_MATCH3_HIGH = 8'h14;
  localparam logic [7:0] MAF_OFS_MATCH4_LOW  = 8'h18;
  localparam logic [7:0] MAF_OFS_MATCH4_HIGH = 8'h1C;
  localparam logic [7:0] MAF_OFS_TYPE_LEN    = 8'h20;
  localparam logic [7:0] MAF_OFS_PAUSE_QUANT = 8'h24;
  localparam logic [7:0] MAF_OFS_USER_IO     = 8'h28;
  localparam logic [7:0] MAF_OFS_NET_CONFIG  = 8'h2C;
  localparam logic [7:0] MAF_OFS_STATUS      = 8'h30;

  // Stride between match slots
  localparam logic [7:0] MAF_SLOT_STRIDE = 8'h08;

  ////////////////////////////////////////////////////////////////////////////
  // Field positions
  localparam int MAF_UIO_MII_BIT        = 0;
  localparam int MAF_UIO_COPY_ALL_BIT   = 1;
  localparam int MAF_UIO_PAUSE_TRIG_BIT = 2;
  localparam int MAF_UIO_PAUSE_ZERO_BIT = 3;
  localparam int MAF_UIO_WIDTH          = 4;
  localparam int MAF_NCFG_EXT_MATCH_BIT = 0;
  localparam int MAF_STAT_SLOT_LSB      = 0;
  localparam int MAF_STAT_HIT_LSB       = 4;
  localparam int MAF_STAT_TYPE_HIT_BIT  = 8;
  localparam int MAF_STAT_PEND_LSB      = 16;

  ////////////////////////////////////////////////////////////////////////////
  // Sizes and reset values
  localparam int                  MAF_SLOTS         = 4;
  localparam int                  MAF_HIGH_WIDTH    = 16;
  localparam int                  MAF_TYPE_WIDTH    = 16;
  localparam int                  MAF_PEND_WIDTH    = 4;
  localparam logic [31:0]         MAF_RST_WORD      = 32'h0000_0000;
  localparam logic [15:0]         MAF_RST_HALF      = 16'h0000;
  localparam logic [3:0]          MAF_RST_USER_IO   = 4'h0;

  // AHB encodings
  localparam logic [1:0] MAF_HTRANS_NONSEQ = 2'h2;
  localparam logic [1:0] MAF_HTRANS_SEQ    = 2'h3;

endpackage

// ---- rtl/maf_match_slot.sv ----
// One destination address match slot
`timescale 1ns/1ps
module maf_match_slot
  import maf_pkg::*;
(
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic [31:0] addr_low,
  input  wire logic [15:0] addr_high,
  input  wire logic        slot_on,
  input  wire logic [47:0] rx_dest,
  input  wire logic        rx_strobe,
  output logic             hit
);

  typedef struct packed {
    logic hit;
  } maf_slot_state_type;

  maf_slot_state_type s;
  maf_slot_state_type next_s;

  ////////////////////////////////////////////////////////////////////////////
  // Compare, registered
  always_comb
  begin
    next_s     = s;
    next_s.hit = rx_strobe && slot_on && (rx_dest == {addr_high, addr_low});
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      s <= '0;
    else
      s <= next_s;
  end

  assign hit = s.hit;

endmodule

// ---- rtl/maf_filter.sv ----
// MAC address filter, type compare, pause trigger and user I/O registers
`timescale 1ns/1ps
module maf_filter
  import maf_pkg::*;
#(
  parameter int PEND_WIDTH = MAF_PEND_WIDTH
)
(
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  input  wire logic [47:0] rx_dest_addr,
  input  wire logic [15:0] rx_type_len,
  input  wire logic        rx_hdr_valid,
  output logic [3:0]       rx_addr_match,
  output logic             rx_type_match,
  output logic             rx_match_valid,
  output logic             rx_copy_all,
  output logic             phy_mii_mode,
  output logic             pause_tx_req,
  output logic [15:0]      pause_tx_quantum,
  input  wire logic        pause_tx_done
);

  typedef struct packed {
    logic [MAF_SLOTS-1:0][31:0]             addr_low;
    logic [MAF_SLOTS-1:0][MAF_HIGH_WIDTH-1:0] addr_high;
    logic [MAF_SLOTS-1:0]                   slot_on;
    logic [MAF_TYPE_WIDTH-1:0]              type_cmp;
    logic [15:0]                            pause_quant;
    logic [MAF_UIO_WIDTH-1:0]               user_io;
    logic                                   ext_match;
    logic [PEND_WIDTH-1:0]                  pend;
    logic                                   wr_pend;
    logic [7:0]                             wr_ofs;
    logic [31:0]                            rdata;
    logic                                   type_hit;
    logic                                   match_vld;
    logic                                   copy_all;
    logic                                   mii;
    logic                                   pause_req;
    logic [15:0]                            quant_out;
  } maf_state_type;

  maf_state_type        s;
  maf_state_type        next_s;
  logic [MAF_SLOTS-1:0] slot_hit;
  logic                 addr_phase;
  logic [7:0]           addr_ofs;
  logic                 trig_toggle;

  ////////////////////////////////////////////////////////////////////////////
  // Match slots
  genvar g;
  generate
    for (g = 0; g < MAF_SLOTS; g = g + 1)
    begin : gen_slot
      maf_match_slot u_slot (
        .hclk      (hclk),
        .hresetn   (hresetn),
        .addr_low  (s.addr_low[g]),
        .addr_high (s.addr_high[g]),
        .slot_on   (s.slot_on[g]),
        .rx_dest   (rx_dest_addr),
        .rx_strobe (rx_hdr_valid),
        .hit       (slot_hit[g])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Bus decode
  assign addr_phase = hsel && hready && (htrans == MAF_HTRANS_NONSEQ || htrans == MAF_HTRANS_SEQ);
  assign addr_ofs   = {haddr[7:2], 2'b00};

  ////////////////////////////////////////////////////////////////////////////
  // Next state
  always_comb
  begin
    next_s      = s;
    trig_toggle = 1'b0;

    // Write data phase
    if (s.wr_pend)
    begin
      next_s.wr_pend = 1'b0;
      for (int i = 0; i < MAF_SLOTS; i++)
      begin
        if (s.wr_ofs == MAF_OFS_MATCH1_LOW + MAF_SLOT_STRIDE * 8'(i))
        begin
          next_s.addr_low[i] = hwdata;
          next_s.slot_on[i]  = 1'b0;
        end
        if (s.wr_ofs == MAF_OFS_MATCH1_HIGH + MAF_SLOT_STRIDE * 8'(i))
        begin
          next_s.addr_high[i] = hwdata[MAF_HIGH_WIDTH-1:0];
          next_s.slot_on[i]   = 1'b1;
        end
      end
      case (s.wr_ofs)
        MAF_OFS_TYPE_LEN:
          next_s.type_cmp = hwdata[MAF_TYPE_WIDTH-1:0];
        MAF_OFS_PAUSE_QUANT:
          next_s.pause_quant = hwdata[15:0];
        MAF_OFS_USER_IO:
        begin
          next_s.user_io = hwdata[MAF_UIO_WIDTH-1:0];
          trig_toggle    = hwdata[MAF_UIO_PAUSE_TRIG_BIT] != s.user_io[MAF_UIO_PAUSE_TRIG_BIT];
        end
        MAF_OFS_NET_CONFIG:
          next_s.ext_match = hwdata[MAF_NCFG_EXT_MATCH_BIT];
        default:
          next_s.wr_pend = 1'b0;
      endcase
    end

    // Pending pause frames; a new toggle beside a done keeps the count
    if (trig_toggle && !pause_tx_done)
    begin
      if (s.pend != {PEND_WIDTH{1'b1}})
        next_s.pend = s.pend + PEND_WIDTH'(1);
    end
    else if (!trig_toggle && pause_tx_done && s.pend != '0)
    begin
      next_s.pend = s.pend - PEND_WIDTH'(1);
    end

    // Address phase capture; writes outside the window are dropped
    if (addr_phase && hwrite)
    begin
      next_s.wr_pend = haddr[31:8] == 24'h00_0000;
      next_s.wr_ofs  = addr_ofs;
    end

    // Read data, taken after any write of this cycle
    if (addr_phase && !hwrite)
    begin
      next_s.rdata = MAF_RST_WORD;
      for (int i = 0; i < MAF_SLOTS; i++)
      begin
        if (addr_ofs == MAF_OFS_MATCH1_LOW + MAF_SLOT_STRIDE * 8'(i))
          next_s.rdata = next_s.addr_low[i];
        if (addr_ofs == MAF_OFS_MATCH1_HIGH + MAF_SLOT_STRIDE * 8'(i))
          next_s.rdata = {16'h0000, next_s.addr_high[i]};
      end
      case (addr_ofs)
        MAF_OFS_TYPE_LEN:
          next_s.rdata = {16'h0000, next_s.type_cmp};
        MAF_OFS_PAUSE_QUANT:
          next_s.rdata = {16'h0000, next_s.pause_quant};
        MAF_OFS_USER_IO:
          next_s.rdata = {28'h000_0000, next_s.user_io};
        MAF_OFS_NET_CONFIG:
          next_s.rdata = {31'h0000_0000, next_s.ext_match};
        MAF_OFS_STATUS:
        begin
          next_s.rdata[MAF_STAT_SLOT_LSB +: MAF_SLOTS]     = next_s.slot_on;
          next_s.rdata[MAF_STAT_HIT_LSB +: MAF_SLOTS]      = slot_hit;
          next_s.rdata[MAF_STAT_TYPE_HIT_BIT]              = s.type_hit;
          next_s.rdata[MAF_STAT_PEND_LSB +: PEND_WIDTH]    = next_s.pend;
        end
        default:
          next_s.rdata = next_s.rdata;
      endcase
      if (haddr[31:8] != 24'h00_0000)
        next_s.rdata = MAF_RST_WORD;
    end

    // Receive side compares
    next_s.type_hit  = rx_hdr_valid && (rx_type_len == s.type_cmp);
    next_s.match_vld = rx_hdr_valid;
    next_s.copy_all  = rx_hdr_valid && s.ext_match && s.user_io[MAF_UIO_COPY_ALL_BIT];

    // Link side outputs
    next_s.mii       = next_s.user_io[MAF_UIO_MII_BIT];
    next_s.pause_req = next_s.pend != '0;
    next_s.quant_out = next_s.user_io[MAF_UIO_PAUSE_ZERO_BIT] ? MAF_RST_HALF : next_s.pause_quant;
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      s             <= '0;
      s.user_io     <= MAF_RST_USER_IO;
      s.type_cmp    <= MAF_RST_HALF;
      s.pause_quant <= MAF_RST_HALF;
    end
    else
    begin
      s <= next_s;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs
  assign hreadyout        = 1'b1;
  assign hresp            = 1'b0;
  assign hrdata           = s.rdata;
  assign rx_addr_match    = slot_hit;
  assign rx_type_match    = s.type_hit;
  assign rx_match_valid   = s.match_vld;
  assign rx_copy_all      = s.copy_all;
  assign phy_mii_mode     = s.mii;
  assign pause_tx_req     = s.pause_req;
  assign pause_tx_quantum = s.quant_out;

endmodule

// ---- tb/maf_chk.sv ----
// Checker for receive result pulses, mode and pause request timing
`timescale 1ns/1ps
module maf_chk
(
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic        hsel,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic        hready,
  input wire logic        rx_hdr_valid,
  input wire logic [3:0]  rx_addr_match,
  input wire logic        rx_type_match,
  input wire logic        rx_match_valid,
  input wire logic        rx_copy_all,
  input wire logic        phy_mii_mode,
  input wire logic        pause_tx_req,
  input wire logic [15:0] pause_tx_quantum,
  input wire logic        pause_tx_done
);
  logic wr_take;
  assign wr_take = hsel & hwrite & htrans[1] & hready;
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  sequence s_lone_hdr;
    rx_hdr_valid ##1 !rx_hdr_valid;
  endsequence
  sequence s_one_pulse;
    rx_match_valid ##1 !rx_match_valid;
  endsequence
  property p_res_pulse;
    s_lone_hdr |-> s_one_pulse;
  endproperty
  a_res_pulse: assert property (p_res_pulse) else $error("result pulse wrong");
  property p_res_cause;
    rx_match_valid |-> $past(rx_hdr_valid);
  endproperty
  a_res_cause: assert property (p_res_cause) else $error("result without header");
  property p_hit_qual;
    rx_addr_match != 4'h0 |-> rx_match_valid;
  endproperty
  a_hit_qual: assert property (p_hit_qual) else $error("hit outside result");
  property p_type_qual;
    rx_type_match |-> rx_match_valid;
  endproperty
  a_type_qual: assert property (p_type_qual) else $error("type hit outside result");
  property p_copy_qual;
    rx_copy_all |-> rx_match_valid;
  endproperty
  a_copy_qual: assert property (p_copy_qual) else $error("copy outside result");
  property p_mii_cause;
    $changed(phy_mii_mode) |-> $past(wr_take, 2);
  endproperty
  a_mii_cause: assert property (p_mii_cause) else $error("mode moved without write");
  property p_quant_cause;
    $changed(pause_tx_quantum) |-> $past(wr_take, 2);
  endproperty
  a_quant_cause: assert property (p_quant_cause) else $error("quantum moved without write");
  property p_req_rise;
    $rose(pause_tx_req) |-> $past(wr_take, 2);
  endproperty
  a_req_rise: assert property (p_req_rise) else $error("request without write");
  property p_req_fall;
    $fell(pause_tx_req) |-> $past(pause_tx_done);
  endproperty
  a_req_fall: assert property (p_req_fall) else $error("request dropped early");
endmodule
bind maf_filter maf_chk u_chk (.hclk, .hresetn, .hsel, .htrans, .hwrite, .hready, .rx_hdr_valid, .rx_addr_match,
  .rx_type_match, .rx_match_valid, .rx_copy_all, .phy_mii_mode, .pause_tx_req, .pause_tx_quantum, .pause_tx_done);

// ---- tb/maf_tx_model.sv ----
// Pause frame transmitter stand-in
`timescale 1ns/1ps
module maf_tx_model
(
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        pause_tx_req,
  input  wire logic [15:0] pause_tx_quantum,
  input  wire logic [7:0]  delay,
  output logic             pause_tx_done,
  output logic [7:0]       frames,
  output logic [15:0]      last_q
);
  logic [7:0] cnt;
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
    begin
      cnt <= 8'h00;
      pause_tx_done <= 1'b0;
      frames <= 8'h00;
      last_q <= 16'h0000;
    end
    else
    begin
      pause_tx_done <= 1'b0;
      if (pause_tx_done || !pause_tx_req)
        cnt <= 8'h00;
      else if (cnt >= delay)
      begin
        pause_tx_done <= 1'b1;
        frames <= frames + 8'h01;
        last_q <= pause_tx_quantum;
        cnt <= 8'h00;
      end
      else
        cnt <= cnt + 8'h01;
    end
endmodule

// ---- tb/tb.sv ----
// Testbench for the address filter and user I/O block
`timescale 1ns/1ps
module tb;
  import maf_pkg::*;
  logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, rx_hdr_valid = 0;
  logic [31:0] haddr = '0, hwdata = '0, hrdata, r;
  logic [1:0] htrans = '0;
  logic [2:0] hsize = 3'h2;
  logic [47:0] rx_dest_addr = '0;
  logic [15:0] rx_type_len = '0, pause_tx_quantum, last_q;
  logic [3:0] rx_addr_match;
  logic hreadyout, hresp, rx_type_match, rx_match_valid, rx_copy_all, phy_mii_mode, pause_tx_req, pause_tx_done;
  logic [7:0] delay = 8'h00, frames;
  int error_cnt = 0, n_compared = 0;
  always #20 hclk = ~hclk;
  maf_filter dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready(hreadyout), .hreadyout,
    .hresp, .hrdata, .rx_dest_addr, .rx_type_len, .rx_hdr_valid, .rx_addr_match, .rx_type_match, .rx_match_valid,
    .rx_copy_all, .phy_mii_mode, .pause_tx_req, .pause_tx_quantum, .pause_tx_done);
  maf_tx_model phy (.hclk, .hresetn, .pause_tx_req, .pause_tx_quantum, .delay, .pause_tx_done, .frames, .last_q);
  ////////////////////////////////////////////////////////////////////////////
  task complete_run;
    if (error_cnt == 0 && n_compared > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task chk(input logic [47:0] got, input logic [47:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("MISMATCH %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task rdy;
    int i;
    i = 0;
    @(posedge hclk);
    while (hreadyout !== 1'b1)
    begin
      if (++i > 50)
      begin
        error_cnt++;
        complete_run;
      end
      @(posedge hclk);
    end
  endtask
  task xfer(input logic w, input logic [31:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= MAF_HTRANS_NONSEQ;
    hwrite <= w;
    rdy;
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    rdy;
    r = hrdata;
    #1;
  endtask
  task rx(input logic [47:0] a, input logic [15:0] t);
    rx_dest_addr <= a;
    rx_type_len <= t;
    rx_hdr_valid <= 1'b1;
    @(posedge hclk);
    rx_hdr_valid <= 1'b0;
    #1;
  endtask
  task wait_frames(input logic [7:0] n);
    int i;
    i = 0;
    while (frames !== n)
    begin
      @(posedge hclk);
      if (++i > 200)
      begin
        error_cnt++;
        complete_run;
      end
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task t_regs;
    for (int i = 0; i < 12; i++)
    begin
      xfer(1'b0, 32'(i * 4), 32'h0);
      chk(r, 0);
    end
    xfer(1'b1, 32'h100, 32'hFFFF_FFFF);
    xfer(1'b0, 32'h100, 32'h0);
    chk(r, 0);
    chk(hresp, 0);
    xfer(1'b0, 32'h0, 32'h0);
    chk(r, 0);
    for (int i = 0; i < 11; i++)
    begin
      xfer(1'b1, 32'(i * 4), 32'hA5A5_5A5A ^ 32'(i));
      xfer(1'b0, 32'(i * 4), 32'h0);
      chk(r, (32'hA5A5_5A5A ^ 32'(i)) & ((i == 10) ? 32'hF : (i > 7 || i % 2) ? 32'hFFFF : 32'hFFFF_FFFF));
    end
  endtask
  task t_match;
    for (int k = 0; k < 4; k++)
    begin
      xfer(1'b1, 32'(k * 8), 32'h4433_2211 + 32'(k));
      xfer(1'b1, 32'(k * 8 + 4), 32'h6655);
    end
    xfer(1'b0, 32'h30, 32'h0);
    chk(r, 32'hF);
    for (int k = 0; k < 4; k++)
    begin
      rx({16'h6655, 32'h4433_2211 + 32'(k)}, 16'h0800);
      chk(rx_addr_match, 48'h1 << k);
    end
    rx({16'h6655, 32'h4433_2210}, 16'h0800);
    chk(rx_addr_match, 0);
    xfer(1'b1, 32'h20, 32'h8870);
    rx(48'h0, 16'h8870);
    chk({rx_match_valid, rx_type_match}, 2'h3);
    rx(48'h0, 16'h8871);
    chk({rx_match_valid, rx_type_match}, 2'h2);
    xfer(1'b1, 32'h2C, 32'h1);
    xfer(1'b1, 32'h28, 32'h2);
    rx(48'h0, 16'h0);
    chk(rx_copy_all, 1);
    xfer(1'b1, 32'h28, 32'h0);
    rx(48'h0, 16'h0);
    chk(rx_copy_all, 0);
    xfer(1'b1, 32'h2C, 32'h0);
    xfer(1'b1, 32'h28, 32'h2);
    rx(48'h0, 16'h0);
    chk(rx_copy_all, 0);
  endtask
  task t_mode;
    xfer(1'b1, 32'h28, 32'h1);
    chk(phy_mii_mode, 1);
    xfer(1'b1, 32'h28, 32'h0);
    chk(phy_mii_mode, 0);
  endtask
  task t_pause;
    xfer(1'b1, 32'h24, 32'hFFFF_1234);
    xfer(1'b1, 32'h28, 32'h4);
    wait_frames(8'h1);
    chk(last_q, 16'h1234);
    delay <= 8'h03;
    xfer(1'b1, 32'h28, 32'hC);
    xfer(1'b1, 32'h28, 32'h8);
    wait_frames(8'h2);
    chk(last_q, 16'h0);
    xfer(1'b1, 32'h28, 32'h4);
    xfer(1'b1, 32'h28, 32'h0);
    wait_frames(8'h4);
    repeat (20) @(posedge hclk);
    chk({frames, pause_tx_req}, {8'h4, 1'b0});
  endtask
  initial
  begin
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    t_regs;
    t_match;
    t_mode;
    t_pause;
    complete_run;
  end
endmodule
